/* File: logic/mag_event_pkg.sv */
/*
  constants, field layouts and carrier types of the magnetic event and offset control block.
  assumes one 100 MHz clock and a register port that is already decoded to byte addresses.
*/
// Notes on behaviour
// - bypass clear: stored offsets added to samples
// - bypass set: raw samples, offsets ignored
// - three-bit field selects auto-sleep oversampling
// - oversampling count depends on code and rate
// - update select clear: all threshold references
// - update select set: only triggering axis
// - event source bit 0 is data ready
// - event source bit 1 is vector-magnitude event
// - event source bit 2 is threshold event
// - distance above threshold, persisting beyond count
// - compare decimated output with internal references
// - internal references never readable by host
// - zero references give absolute magnitude threshold
// - latch holds flag until source read
// - enable loads references from output or init
package mag_event_pkg;

  localparam logic [7:0] ADDR_CTRL_THREE = 8'h5d;
  localparam logic [7:0] ADDR_EVENT_SRC = 8'h5e;
  localparam logic [7:0] CTRL_THREE_RESET = 8'h00;
  localparam logic [7:0] EVENT_SRC_RESET = 8'h00;

  localparam int CTRL_BYPASS_BIT = 7;
  localparam int CTRL_OS_LSB = 4;
  localparam int CTRL_AXIS_UPD_BIT = 3;
  localparam int SRC_DRDY_BIT = 0;
  localparam int SRC_VECM_BIT = 1;
  localparam int SRC_THS_BIT = 2;

  // oversampling at the slowest rate is 16 << (code - 1), code 0 equal to code 1
  localparam logic [10:0] OS_BASE = 11'h010;
  localparam logic [10:0] OS_FLOOR = 11'h002;

  typedef logic [2:0] os_code_t;
  typedef logic [2:0] odr_sel_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } mag_vec_t;

  typedef struct packed {
    logic ths;
    logic vecm;
    logic drdy;
  } event_flags_t;

endpackage : mag_event_pkg

/* File: logic/mag_event_offset_control.sv */
/*
  offset application, sleep oversampling selection, threshold reference update,
  vector-magnitude change detection and the read-only event source register.
  assumes samples, offsets, detector settings and threshold triggers arrive synchronous to CLK,
  and that the register port presents one decoded access per cycle.
*/
`timescale 1ns/1ns
module mag_event_offset_control (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic SAMPLE_VALID,
  input wire mag_event_pkg::mag_vec_t SAMPLE_RAW,
  input wire mag_event_pkg::mag_vec_t OFFSET,
  input wire mag_event_pkg::odr_sel_t ODR_SEL,
  input wire logic SLEEP_MODE,
  input wire mag_event_pkg::os_code_t ACTIVE_OS_CODE,
  input wire logic THS_TRIG,
  input wire logic [2:0] THS_AXIS,
  input wire logic VECM_EN,
  input wire logic VECM_INITM,
  input wire logic VECM_UPDM,
  input wire logic VECM_ELE,
  input wire logic [15:0] VECM_THS,
  input wire logic [7:0] VECM_CNT,
  input wire mag_event_pkg::mag_vec_t VECM_INIT,
  output mag_event_pkg::mag_vec_t MAG_OUT,
  output logic MAG_OUT_VALID,
  output logic [10:0] OSR_COUNT,
  output mag_event_pkg::mag_vec_t THS_REF,
  output mag_event_pkg::event_flags_t FLAGS
);
  import mag_event_pkg::*;

  function automatic logic [10:0] os_count(input odr_sel_t odr, input os_code_t code);
    logic [10:0] at_slowest;
    logic [3:0] shift;
    logic [10:0] scaled;
    at_slowest = (code == 3'h0) ? OS_BASE : (OS_BASE << (code - 3'h1));
    unique case (odr)
      3'h0: shift = 4'h0;
      3'h1: shift = 4'h2;
      3'h2: shift = 4'h3;
      3'h3: shift = 4'h5;
      3'h4: shift = 4'h6;
      3'h5: shift = 4'h7;
      3'h6: shift = 4'h8;
      3'h7: shift = 4'h9;
    endcase
    scaled = at_slowest >> shift;
    os_count = (scaled < OS_FLOOR) ? OS_FLOOR : scaled;
  endfunction : os_count

  function automatic logic signed [15:0] add_wrap(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) + 17'(b);
    add_wrap = s[15:0];
  endfunction : add_wrap

  function automatic logic [33:0] sq_diff(input logic signed [15:0] a,
                                          input logic signed [15:0] b);
    logic signed [16:0] d;
    logic signed [33:0] p;
    d = 17'(a) - 17'(b);
    p = d * d;
    sq_diff = p;
  endfunction : sq_diff

  ////////////////////////////////////////////////////////////////////////////
  // register port
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] rdata_q, rdata_d;
  logic src_read;
  event_flags_t flags_q, flags_d;

  assign src_read = REG_RD && (REG_ADDR == ADDR_EVENT_SRC);

  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = 8'h00;
    // the event source address takes no write at all
    if (REG_WR && REG_ADDR == ADDR_CTRL_THREE) begin
      ctrl_d = REG_WDATA;
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        ADDR_CTRL_THREE: rdata_d = ctrl_q;
        // upper bits stay zero; references have no register read address
        ADDR_EVENT_SRC: rdata_d = {5'h00, flags_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= CTRL_THREE_RESET;
      rdata_q <= EVENT_SRC_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample path and oversampling
  mag_vec_t out_q, out_d;
  logic out_valid_q, out_valid_d;
  logic [10:0] osr_q, osr_d;
  os_code_t os_sel;

  assign os_sel = SLEEP_MODE ? ctrl_q[CTRL_OS_LSB +: 3] : ACTIVE_OS_CODE;

  always_comb begin
    out_d = out_q;
    out_valid_d = SAMPLE_VALID;
    osr_d = os_count(ODR_SEL, os_sel);
    if (SAMPLE_VALID) begin
      if (ctrl_q[CTRL_BYPASS_BIT]) begin
        out_d = SAMPLE_RAW;
      end else begin
        out_d.x = add_wrap(SAMPLE_RAW.x, OFFSET.x);
        out_d.y = add_wrap(SAMPLE_RAW.y, OFFSET.y);
        out_d.z = add_wrap(SAMPLE_RAW.z, OFFSET.z);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      out_q <= '0;
      out_valid_q <= 1'b0;
      osr_q <= OS_FLOOR;
    end else begin
      out_q <= out_d;
      out_valid_q <= out_valid_d;
      osr_q <= osr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // threshold references
  mag_vec_t ths_ref_q, ths_ref_d;
  logic [2:0] ths_upd;

  assign ths_upd = ctrl_q[CTRL_AXIS_UPD_BIT] ? THS_AXIS : 3'h7;

  always_comb begin
    ths_ref_d = ths_ref_q;
    if (THS_TRIG) begin
      if (ths_upd[2]) ths_ref_d.x = out_q.x;
      if (ths_upd[1]) ths_ref_d.y = out_q.y;
      if (ths_upd[0]) ths_ref_d.z = out_q.z;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ths_ref_q <= '0;
    end else begin
      ths_ref_q <= ths_ref_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector-magnitude detector; squares avoid a root, the threshold is squared too
  mag_vec_t vref_q, vref_d;
  logic en_q, en_d;
  logic [7:0] run_q, run_d;
  logic vecm_hit;
  logic over;
  logic [35:0] dist2;
  logic [35:0] ths2;
  logic [7:0] run_next;

  assign dist2 = 36'(sq_diff(out_d.x, vref_q.x)) + 36'(sq_diff(out_d.y, vref_q.y))
               + 36'(sq_diff(out_d.z, vref_q.z));
  assign ths2 = 36'(VECM_THS) * 36'(VECM_THS);
  assign over = en_q && VECM_EN && (dist2 > ths2);
  assign run_next = (run_q == 8'hff) ? run_q : run_q + 8'h01;
  assign vecm_hit = SAMPLE_VALID && over && (run_next > VECM_CNT);

  always_comb begin
    vref_d = vref_q;
    en_d = VECM_EN;
    run_d = run_q;
    if (SAMPLE_VALID) begin
      run_d = over ? run_next : 8'h00;
    end
    if (VECM_EN && !en_q) begin
      vref_d = VECM_INITM ? VECM_INIT : out_q;
      run_d = 8'h00;
    end else if (VECM_EN && VECM_INITM && VECM_UPDM) begin
      vref_d = VECM_INIT;
    end else if (vecm_hit && !VECM_UPDM) begin
      vref_d = out_d;
      run_d = 8'h00;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      vref_q <= '0;
      en_q <= 1'b0;
      run_q <= 8'h00;
    end else begin
      vref_q <= vref_d;
      en_q <= en_d;
      run_q <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event source flags; a new event in the read cycle survives the clear

  always_comb begin
    flags_d = flags_q;
    if (src_read) begin
      flags_d = '0;
    end
    if (out_valid_d) flags_d.drdy = 1'b1;
    if (THS_TRIG) flags_d.ths = 1'b1;
    if (VECM_ELE) begin
      if (vecm_hit) flags_d.vecm = 1'b1;
    end else if (SAMPLE_VALID) begin
      flags_d.vecm = vecm_hit;
    end else begin
      flags_d.vecm = flags_q.vecm;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign MAG_OUT = out_q;
  assign MAG_OUT_VALID = out_valid_q;
  assign OSR_COUNT = osr_q;
  assign THS_REF = ths_ref_q;
  assign FLAGS = flags_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence ctrl_written_s;
    REG_WR && REG_ADDR == ADDR_CTRL_THREE;
  endsequence

  offset_applied_a: assert property (SAMPLE_VALID && !ctrl_q[CTRL_BYPASS_BIT]
      |=> MAG_OUT.x == add_wrap($past(SAMPLE_RAW.x), $past(OFFSET.x)))
    else $error("offset not applied");
  bypass_raw_a: assert property (SAMPLE_VALID && ctrl_q[CTRL_BYPASS_BIT]
      |=> MAG_OUT == $past(SAMPLE_RAW))
    else $error("bypass output not raw");
  sleep_os_a: assert property (ctrl_written_s ##1 SLEEP_MODE && ODR_SEL == 3'h0
      && ctrl_q[CTRL_OS_LSB +: 3] == 3'h7 |=> OSR_COUNT == 11'h400)
    else $error("sleep oversampling wrong");
  os_floor_a: assert property (OSR_COUNT >= OS_FLOOR)
    else $error("oversampling below floor");
  ref_all_a: assert property (THS_TRIG && !ctrl_q[CTRL_AXIS_UPD_BIT]
      |=> THS_REF == $past(out_q))
    else $error("references not all updated");
  ref_axis_a: assert property (THS_TRIG && ctrl_q[CTRL_AXIS_UPD_BIT] && THS_AXIS == 3'h2
      |=> THS_REF.x == $past(THS_REF.x) && THS_REF.y == $past(out_q.y))
    else $error("single axis update wrong");
  src_read_a: assert property (src_read |=> REG_RDATA == {5'h00, $past(flags_q)})
    else $error("event source read wrong");
  ths_flag_a: assert property (THS_TRIG |=> FLAGS.ths)
    else $error("threshold flag not set");
  vecm_latch_a: assert property (VECM_ELE && FLAGS.vecm && !src_read ##0 VECM_ELE[*1]
      |=> FLAGS.vecm)
    else $error("latched flag dropped");
  vecm_hit_a: assert property (vecm_hit |=> FLAGS.vecm ##1 REG_RDATA[7:3] == 5'h00)
    else $error("vector event lost");
  vecm_init_a: assert property ($rose(VECM_EN) && VECM_INITM
      |=> vref_q == $past(VECM_INIT))
    else $error("reference init wrong");
  no_write_src_a: assert property (REG_WR && REG_ADDR == ADDR_EVENT_SRC
      |=> ctrl_q == $past(ctrl_q))
    else $error("event source write took effect");

endmodule : mag_event_offset_control

/* File: dv/tb_top.sv */
/*
  self-checking bench of the magnetic event and offset control block.
  assumes the decoded byte register port and one 100 MHz clock; all inputs driven here.
*/
`timescale 1ns/1ns
module tb_top;
  import mag_event_pkg::*;
  logic CLK = 0, RST_N = 0, REG_WR = 0, REG_RD = 0, SAMPLE_VALID = 0, SLEEP_MODE = 1;
  logic THS_TRIG = 0, VECM_EN = 0, VECM_INITM = 1, VECM_UPDM = 1, VECM_ELE = 1;
  logic [7:0] REG_ADDR = '0, REG_WDATA = '0, REG_RDATA, VECM_CNT = 8'h02;
  logic [2:0] THS_AXIS = '0;
  logic [15:0] VECM_THS = 16'h0064;
  mag_vec_t SAMPLE_RAW = '0, OFFSET = '0, VECM_INIT = '0, MAG_OUT, THS_REF;
  odr_sel_t ODR_SEL = '0;
  os_code_t ACTIVE_OS_CODE = '0;
  logic MAG_OUT_VALID;
  logic [10:0] OSR_COUNT;
  event_flags_t FLAGS;
  int error_cnt = 0, cmp_count = 0, cycles = 0;
  int sh[8] = '{0, 2, 3, 5, 6, 7, 8, 9};
  logic [10:0] e;

  mag_event_offset_control mag_event_offset_control_i (.CLK(CLK), .RST_N(RST_N),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_RAW(SAMPLE_RAW),
    .OFFSET(OFFSET), .ODR_SEL(ODR_SEL), .SLEEP_MODE(SLEEP_MODE),
    .ACTIVE_OS_CODE(ACTIVE_OS_CODE), .THS_TRIG(THS_TRIG), .THS_AXIS(THS_AXIS),
    .VECM_EN(VECM_EN), .VECM_INITM(VECM_INITM), .VECM_UPDM(VECM_UPDM),
    .VECM_ELE(VECM_ELE), .VECM_THS(VECM_THS), .VECM_CNT(VECM_CNT), .VECM_INIT(VECM_INIT),
    .MAG_OUT(MAG_OUT), .MAG_OUT_VALID(MAG_OUT_VALID), .OSR_COUNT(OSR_COUNT),
    .THS_REF(THS_REF), .FLAGS(FLAGS));

  initial begin
    forever #5 CLK = ~CLK;
  end

  // a hang costs no more than this ceiling; the whole run is a few hundred cycles
  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] s, input logic [63:0] x);
    cmp_count++;
    if (s !== x) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  // read data is looked at just after the edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 chk(64'(REG_RDATA), 64'(x));
  endtask : rd

  task automatic smp(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge CLK);
    SAMPLE_VALID <= 1'b1;
    SAMPLE_RAW <= {x, y, z};
    @(posedge CLK);
    SAMPLE_VALID <= 1'b0;
    #1 chk(64'(MAG_OUT_VALID), 64'h1);
  endtask : smp

  task automatic trig(input logic [2:0] ax);
    @(posedge CLK);
    THS_TRIG <= 1'b1;
    THS_AXIS <= ax;
    @(posedge CLK);
    THS_TRIG <= 1'b0;
    #1 chk(64'(FLAGS.ths), 64'h1);
  endtask : trig

  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(ADDR_CTRL_THREE, 8'h00);
    rd(ADDR_EVENT_SRC, 8'h00);
    wr(ADDR_EVENT_SRC, 8'hff);
    rd(ADDR_EVENT_SRC, 8'h00);
    rd(8'h40, 8'h00);
  endtask : t_regs

  task automatic t_offset();
    OFFSET <= {16'h0005, 16'hfffd, 16'h0064};
    smp(16'h0064, 16'h00c8, 16'h012c);
    chk(64'(MAG_OUT), 64'({16'h0069, 16'h00c5, 16'h0190}));
    rd(ADDR_EVENT_SRC, 8'h01);
    rd(ADDR_EVENT_SRC, 8'h00);
    wr(ADDR_CTRL_THREE, 8'h80);
    smp(16'h0064, 16'h00c8, 16'h012c);
    chk(64'(MAG_OUT), 64'({16'h0064, 16'h00c8, 16'h012c}));
  endtask : t_offset

  task automatic t_osr();
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge CLK);
        ODR_SEL <= 3'(r);
        wr(ADDR_CTRL_THREE, {1'b1, 3'(c), 4'h0});
        repeat (2) @(posedge CLK);
        e = ((c == 0) ? 11'h010 : (11'h010 << (c - 1))) >> sh[r];
        if (e < 11'h002) e = 11'h002;
        #1 chk(64'(OSR_COUNT), 64'(e));
      end
    end
    SLEEP_MODE <= 1'b0;
    ODR_SEL <= 3'h0;
    ACTIVE_OS_CODE <= 3'h7;
    repeat (3) @(posedge CLK);
    #1 chk(64'(OSR_COUNT), 64'h400);
  endtask : t_osr

  task automatic t_ths();
    wr(ADDR_CTRL_THREE, 8'h80);
    smp(16'h000a, 16'h0014, 16'h001e);
    trig(3'b001);
    chk(64'(THS_REF), 64'({16'h000a, 16'h0014, 16'h001e}));
    wr(ADDR_CTRL_THREE, 8'h8f);
    rd(ADDR_CTRL_THREE, 8'h8f);
    smp(16'h0028, 16'h0032, 16'h003c);
    trig(3'b010);
    chk(64'(THS_REF), 64'({16'h000a, 16'h0032, 16'h001e}));
    rd(ADDR_EVENT_SRC, 8'h05);
  endtask : t_ths

  task automatic t_vecm();
    smp(16'h0000, 16'h0000, 16'h0000);
    @(posedge CLK);
    VECM_EN <= 1'b1;
    rd(ADDR_EVENT_SRC, 8'h01);
    smp(16'h00c8, 16'h0000, 16'h0000);
    chk(64'(FLAGS.vecm), 64'h0);
    repeat (4) smp(16'h00c8, 16'h0000, 16'h0000);
    chk(64'(FLAGS.vecm), 64'h1);
    smp(16'h0000, 16'h0000, 16'h0000);
    chk(64'(FLAGS.vecm), 64'h1);
    rd(ADDR_EVENT_SRC, 8'h03);
    chk(64'(FLAGS), 64'h0);
    @(posedge CLK);
    VECM_EN <= 1'b0;
    VECM_INITM <= 1'b0;
    smp(16'h012c, 16'h0000, 16'h0000);
    @(posedge CLK);
    VECM_EN <= 1'b1;
    repeat (5) smp(16'h012c, 16'h0000, 16'h0000);
    chk(64'(FLAGS.vecm), 64'h0);
    repeat (5) smp(16'h01c2, 16'h0000, 16'h0000);
    chk(64'(FLAGS.vecm), 64'h1);
    VECM_ELE <= 1'b0;
    smp(16'h012c, 16'h0000, 16'h0000);
    chk(64'(FLAGS.vecm), 64'h0);
    // update mode: the event moves the references onto the new field
    VECM_UPDM <= 1'b0;
    VECM_ELE <= 1'b1;
    repeat (3) smp(16'h01c2, 16'h0000, 16'h0000);
    rd(ADDR_EVENT_SRC, 8'h03);
    repeat (3) smp(16'h01c2, 16'h0000, 16'h0000);
    chk(64'(FLAGS.vecm), 64'h0);
  endtask : t_vecm

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    #1 chk(64'(OSR_COUNT), 64'h2);
    t_regs();
    t_offset();
    t_ths();
    t_osr();
    t_vecm();
    conclude();
  end
endmodule : tb_top
